// ===== core/hds_pkg.sv
// Purpose: shared constants and types for the headphone start-up and dc servo control block
// Assumes: 16-bit registers at 8-bit addresses, core clock of 100 MHz
// Notes: all registers reset to zero
package hds_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] HDS_A_PWR1 = 8'h01;
	localparam logic [7:0] HDS_A_PWR2 = 8'h02;
	localparam logic [7:0] HDS_A_MIXEN = 8'h03;
	localparam logic [7:0] HDS_A_IN1_LINE = 8'h16;
	localparam logic [7:0] HDS_A_FIRST_INPUT_A_VOL = 8'h18;
	localparam logic [7:0] HDS_A_FIRST_INPUT_B_VOL = 8'h19;
	localparam logic [7:0] HDS_A_LGAIN = 8'h1C;
	localparam logic [7:0] HDS_A_RGAIN = 8'h1D;
	localparam logic [7:0] HDS_A_PATH_L = 8'h2D;
	localparam logic [7:0] HDS_A_PATH_R = 8'h2E;
	localparam logic [7:0] HDS_A_MUTE_L = 8'h2F;
	localparam logic [7:0] HDS_A_MUTE_R = 8'h30;
	localparam logic [7:0] HDS_A_SEQ_EN = 8'h46;
	localparam logic [7:0] HDS_A_SEQ_GO = 8'h47;
	localparam logic [7:0] HDS_A_PUMP = 8'h4C;
	localparam logic [7:0] HDS_A_SRV_CTL = 8'h54;
	localparam logic [7:0] HDS_A_SRV_VAL = 8'h57;
	localparam logic [7:0] HDS_A_SRV_STAT = 8'h58;
	localparam logic [7:0] HDS_A_HP_STAGE = 8'h60;
	localparam int HDS_NREG = 18;
	localparam logic [15:0] HDS_REG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int HDS_OSC_BIT = 3;
	localparam int HDS_PUMP_BIT = 15;
	localparam int HDS_SEQ_EN_BIT = 8;
	localparam int HDS_SEQ_GO_BIT = 8;
	localparam int HDS_LOUT_BIT = 9;
	localparam int HDS_ROUT_BIT = 8;
	localparam int HDS_ENA_LSB = 0;
	localparam int HDS_STORED_TRIG_LSB = 2;
	localparam int HDS_BOOT_TRIG_LSB = 4;
	localparam int HDS_ANY_DONE_LSB = 8;
	localparam int HDS_STORED_DONE_LSB = 4;
	localparam int HDS_BOOT_DONE_LSB = 0;
	localparam int HDS_VAL_W = 8;
	localparam int HDS_GAIN_W = 6;

	// sequencer entry: {last, delay, data, start, width, addr}
	localparam int HDS_ENT_ADDR_LSB = 0;
	localparam int HDS_ENT_WIDTH_LSB = 8;
	localparam int HDS_ENT_START_LSB = 12;
	localparam int HDS_ENT_DATA_LSB = 16;
	localparam int HDS_ENT_DELAY_LSB = 24;
	localparam int HDS_ENT_LAST_BIT = 28;
	localparam int HDS_ENT_W = 29;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int HDS_CLK_PERIOD_NS = 10;
	localparam int HDS_BOOT_TIME_US = 25000;
	localparam int HDS_STORED_TIME_US = 2000;
	localparam int HDS_SEQ_UNIT_NS = 63500;
	localparam int HDS_BOOT_CYC = HDS_BOOT_TIME_US * 1000 / HDS_CLK_PERIOD_NS;
	localparam int HDS_STORED_CYC = HDS_STORED_TIME_US * 1000 / HDS_CLK_PERIOD_NS;
	localparam int HDS_SEQ_UNIT_CYC = HDS_SEQ_UNIT_NS / HDS_CLK_PERIOD_NS;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WRITE, SEQ_WAIT} hds_seq_e;
	typedef enum logic [1:0] {SRV_IDLE, SRV_BOOT, SRV_STORED} hds_srv_e;

	// maps an address to {hit, storage index}
	function automatic logic [5:0] hds_map(input logic [7:0] a);
		case (a)
			HDS_A_PWR1: hds_map = 6'h20;
			HDS_A_PWR2: hds_map = 6'h21;
			HDS_A_MIXEN: hds_map = 6'h22;
			HDS_A_IN1_LINE: hds_map = 6'h23;
			HDS_A_FIRST_INPUT_A_VOL: hds_map = 6'h24;
			HDS_A_FIRST_INPUT_B_VOL: hds_map = 6'h25;
			HDS_A_LGAIN: hds_map = 6'h26;
			HDS_A_RGAIN: hds_map = 6'h27;
			HDS_A_PATH_L: hds_map = 6'h28;
			HDS_A_PATH_R: hds_map = 6'h29;
			HDS_A_MUTE_L: hds_map = 6'h2A;
			HDS_A_MUTE_R: hds_map = 6'h2B;
			HDS_A_SEQ_EN: hds_map = 6'h2C;
			HDS_A_SEQ_GO: hds_map = 6'h2D;
			HDS_A_PUMP: hds_map = 6'h2E;
			HDS_A_SRV_CTL: hds_map = 6'h2F;
			HDS_A_SRV_VAL: hds_map = 6'h30;
			HDS_A_HP_STAGE: hds_map = 6'h31;
			default: hds_map = 6'h00;
		endcase
	endfunction

endpackage

// ===== core/hds_ctrl.sv
// Purpose: register file, write sequencer, charge pump control and dc servo for the phones path
// Assumes: reg_* port is the decoded output of the two-wire control interface, on clk
// Notes: servo_cmp_* come from analogue comparators and are synchronised here
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - charge pump runs only while its enable bit 15 is set
// - charge pump mode follows left and right phones gain settings
// - pump clock divided from core clock, which runs only with oscillator on
// - servo enabled per channel; commands act only on enabled channels
// - boot trigger runs a measurement series bringing output within 1mV of ground
// - boot done bit set when boot correction ends, about 25ms
// - stored trigger loads correction from the stored value field directly
// - stored done bit set when stored correction ends, about 2ms
// - any-done status is OR of boot done and stored done per channel
// - bit 5 is right boot trigger, reads 1 while running
// - measured correction stays applied after the series finishes
// - bit 4 is left boot trigger, reads 1 while running
// - status at 9:8 any, 5:4 stored, 1:0 boot; upper bit right
// - stored values 8-bit two's complement, right 15:8, left 7:0
module hds_ctrl
	import hds_pkg::*;
#(
	parameter int BOOT_CYC = HDS_BOOT_CYC,
	parameter int STORED_CYC = HDS_STORED_CYC,
	parameter int SEQ_UNIT_CYC = HDS_SEQ_UNIT_CYC,
	parameter int MEAS_STEPS = 64,
	parameter int SEQ_DEPTH = 16,
	parameter int PUMP_DIV = 8,
	parameter logic [HDS_GAIN_W-1:0] PUMP_GAIN_THRESH = 6'h30
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic prog_wr,
	input wire logic [$clog2(SEQ_DEPTH)-1:0] prog_idx,
	input wire logic [HDS_ENT_W-1:0] prog_entry,
	input wire logic servo_cmp_left,
	input wire logic servo_cmp_right,
	output logic pump_on,
	output logic pump_clk,
	output logic pump_high_mode,
	output logic left_phones_on,
	output logic right_phones_on,
	output logic [7:0] phones_stage,
	output logic servo_left_on,
	output logic servo_right_on,
	output logic [HDS_VAL_W-1:0] left_correction,
	output logic [HDS_VAL_W-1:0] right_correction,
	output logic seq_busy
);

	localparam int IW = $clog2(SEQ_DEPTH);
	localparam int MEAS_CYC = (BOOT_CYC / MEAS_STEPS < 1) ? 1 : BOOT_CYC / MEAS_STEPS;
	localparam logic [31:0] MEAS_LOAD = 32'(MEAS_CYC - 1);
	localparam logic [31:0] STEPS_LOAD = 32'(MEAS_STEPS - 1);
	localparam logic [31:0] STORED_LOAD = 32'(STORED_CYC - 1);
	localparam logic [31:0] UNIT_CYC = 32'(SEQ_UNIT_CYC);
	localparam logic [7:0] DIV_LAST = 8'(PUMP_DIV - 1);
	localparam logic [4:0] I_PWR1 = 5'h00;
	localparam logic [4:0] I_LGAIN = 5'h06;
	localparam logic [4:0] I_RGAIN = 5'h07;
	localparam logic [4:0] I_SEQ_EN = 5'h0C;
	localparam logic [4:0] I_PUMP = 5'h0E;
	localparam logic [4:0] I_SRV_CTL = 5'h0F;
	localparam logic [4:0] I_SRV_VAL = 5'h10;
	localparam logic [4:0] I_HP_STAGE = 5'h11;

	typedef struct packed {
		logic [HDS_NREG-1:0][15:0] regs;
		logic [SEQ_DEPTH-1:0][HDS_ENT_W-1:0] prog;
		hds_seq_e seq;
		logic [IW-1:0] seq_idx;
		logic [31:0] seq_cnt;
		hds_srv_e [1:0] srv;
		logic [1:0][31:0] srv_cnt;
		logic [1:0][31:0] srv_steps;
		logic [1:0][HDS_VAL_W-1:0] corr;
		logic [1:0] boot_done;
		logic [1:0] stored_done;
		logic [1:0] cmp_s1;
		logic [1:0] cmp_s2;
		logic [15:0] rdata;
		logic [7:0] div_cnt;
		logic pump_clk;
		logic pump_on;
		logic pump_high;
		logic busy;
	} hds_state_s;

	hds_state_s st_reg;
	hds_state_s st_next;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr_en;
		logic from_seq;
		logic [7:0] wr_addr;
		logic [15:0] wr_val;
		logic [5:0] hit;
		logic [HDS_ENT_W-1:0] ent;
		logic [15:0] fmask;
		logic [15:0] fdata;
		logic [15:0] old;
		logic [1:0] boot_busy;
		logic [1:0] stored_busy;
		logic [5:0] rhit;
		wr_en = 1'b0;
		from_seq = 1'b0;
		wr_addr = 8'h00;
		wr_val = 16'h0000;
		hit = 6'h00;
		ent = st_reg.prog[st_reg.seq_idx];
		fmask = 16'h0000;
		fdata = 16'h0000;
		old = 16'h0000;
		boot_busy = 2'b00;
		stored_busy = 2'b00;
		rhit = 6'h00;
		st_next = st_reg;

		st_next.cmp_s1 = {servo_cmp_right, servo_cmp_left};
		st_next.cmp_s2 = st_reg.cmp_s1;

		if (prog_wr) begin
			st_next.prog[prog_idx] = prog_entry;
		end

		// the bus wins a collision; the sequencer simply retries its entry next cycle
		if (reg_wr) begin
			wr_en = 1'b1;
			wr_addr = reg_addr;
			wr_val = reg_wdata;
		end else if (st_reg.seq == SEQ_WRITE) begin
			wr_en = 1'b1;
			from_seq = 1'b1;
			wr_addr = ent[HDS_ENT_ADDR_LSB +: 8];
			hit = hds_map(wr_addr);
			old = hit[5] ? st_reg.regs[hit[4:0]] : 16'h0000;
			fmask = ((16'h0001 << ent[HDS_ENT_WIDTH_LSB +: 4]) - 16'h0001)
				<< ent[HDS_ENT_START_LSB +: 4];
			fdata = {8'h00, ent[HDS_ENT_DATA_LSB +: 8]} << ent[HDS_ENT_START_LSB +: 4];
			wr_val = (old & ~fmask) | (fdata & fmask);
		end

		// ----------------------------------------------------------------
		// sequencer
		// ----------------------------------------------------------------
		case (st_reg.seq)
			SEQ_IDLE: st_next.seq = SEQ_IDLE;
			SEQ_WRITE: begin
				if (from_seq) begin
					st_next.seq = SEQ_WAIT;
					st_next.seq_cnt = (ent[HDS_ENT_DELAY_LSB +: 4] == 4'h0) ? 32'h0 :
						UNIT_CYC << ent[HDS_ENT_DELAY_LSB +: 4];
				end
			end
			SEQ_WAIT: begin
				if (st_reg.seq_cnt != 32'h0) begin
					st_next.seq_cnt = st_reg.seq_cnt - 32'h1;
				end else if (ent[HDS_ENT_LAST_BIT] || st_reg.seq_idx == IW'(SEQ_DEPTH - 1)) begin
					st_next.seq = SEQ_IDLE;
				end else begin
					st_next.seq_idx = st_reg.seq_idx + IW'(1);
					st_next.seq = SEQ_WRITE;
				end
			end
			default: st_next.seq = SEQ_IDLE;
		endcase

		// ----------------------------------------------------------------
		// dc servo, one pass per channel
		// ----------------------------------------------------------------
		for (int c = 0; c < 2; c++) begin
			case (st_reg.srv[c])
				SRV_IDLE: st_next.srv[c] = SRV_IDLE;
				SRV_BOOT: begin
					if (!st_reg.regs[I_SRV_CTL][HDS_ENA_LSB + c]) begin
						st_next.srv[c] = SRV_IDLE;
					end else if (st_reg.srv_cnt[c] != 32'h0) begin
						st_next.srv_cnt[c] = st_reg.srv_cnt[c] - 32'h1;
					end else begin
						// comparator high means output above ground: step correction down
						if (st_reg.cmp_s2[c] && st_reg.corr[c] != 8'h80) begin
							st_next.corr[c] = st_reg.corr[c] - 8'h01;
						end else if (!st_reg.cmp_s2[c] && st_reg.corr[c] != 8'h7F) begin
							st_next.corr[c] = st_reg.corr[c] + 8'h01;
						end
						st_next.srv_cnt[c] = MEAS_LOAD;
						if (st_reg.srv_steps[c] == 32'h0) begin
							st_next.srv[c] = SRV_IDLE;
							st_next.boot_done[c] = 1'b1;
						end else begin
							st_next.srv_steps[c] = st_reg.srv_steps[c] - 32'h1;
						end
					end
				end
				SRV_STORED: begin
					if (!st_reg.regs[I_SRV_CTL][HDS_ENA_LSB + c]) begin
						st_next.srv[c] = SRV_IDLE;
					end else if (st_reg.srv_cnt[c] != 32'h0) begin
						st_next.srv_cnt[c] = st_reg.srv_cnt[c] - 32'h1;
					end else begin
						st_next.srv[c] = SRV_IDLE;
						st_next.stored_done[c] = 1'b1;
					end
				end
				default: st_next.srv[c] = SRV_IDLE;
			endcase
		end

		// ----------------------------------------------------------------
		// register write with side effects
		// ----------------------------------------------------------------
		hit = hds_map(wr_addr);
		if (wr_en && hit[5]) begin
			st_next.regs[hit[4:0]] = wr_val;
			if (wr_addr == HDS_A_SRV_CTL) begin
				// trigger bits are not stored; their readback is the busy state
				st_next.regs[hit[4:0]][HDS_BOOT_TRIG_LSB +: 2] = 2'b00;
				st_next.regs[hit[4:0]][HDS_STORED_TRIG_LSB +: 2] = 2'b00;
				for (int c = 0; c < 2; c++) begin
					if (wr_val[HDS_ENA_LSB + c] && wr_val[HDS_BOOT_TRIG_LSB + c]) begin
						st_next.srv[c] = SRV_BOOT;
						st_next.srv_cnt[c] = MEAS_LOAD;
						st_next.srv_steps[c] = STEPS_LOAD;
						st_next.boot_done[c] = 1'b0;
						st_next.stored_done[c] = 1'b0;
					end else if (wr_val[HDS_ENA_LSB + c] && wr_val[HDS_STORED_TRIG_LSB + c]) begin
						st_next.srv[c] = SRV_STORED;
						st_next.srv_cnt[c] = STORED_LOAD;
						st_next.corr[c] = st_reg.regs[I_SRV_VAL][c * HDS_VAL_W +: HDS_VAL_W];
						st_next.boot_done[c] = 1'b0;
						st_next.stored_done[c] = 1'b0;
					end
				end
			end
			if (wr_addr == HDS_A_SEQ_GO) begin
				st_next.regs[hit[4:0]][HDS_SEQ_GO_BIT] = 1'b0;
				if (wr_val[HDS_SEQ_GO_BIT] && st_reg.regs[I_SEQ_EN][HDS_SEQ_EN_BIT]
					&& st_reg.seq == SEQ_IDLE) begin
					st_next.seq = SEQ_WRITE;
					st_next.seq_idx = '0;
				end
			end
		end
		if (!st_next.regs[I_SEQ_EN][HDS_SEQ_EN_BIT]) begin
			st_next.seq = SEQ_IDLE;
		end
		st_next.busy = (st_next.seq != SEQ_IDLE);

		// ----------------------------------------------------------------
		// charge pump
		// ----------------------------------------------------------------
		st_next.pump_on = st_reg.regs[I_PUMP][HDS_PUMP_BIT]
			& st_reg.regs[I_PWR1][HDS_OSC_BIT];
		st_next.pump_high = (st_reg.regs[I_LGAIN][HDS_GAIN_W-1:0] > PUMP_GAIN_THRESH)
			| (st_reg.regs[I_RGAIN][HDS_GAIN_W-1:0] > PUMP_GAIN_THRESH);
		if (st_reg.pump_on) begin
			if (st_reg.div_cnt == DIV_LAST) begin
				st_next.div_cnt = 8'h00;
				st_next.pump_clk = ~st_reg.pump_clk;
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 8'h01;
			end
		end else begin
			st_next.div_cnt = 8'h00;
			st_next.pump_clk = 1'b0;
		end

		// ----------------------------------------------------------------
		// register read
		// ----------------------------------------------------------------
		for (int c = 0; c < 2; c++) begin
			boot_busy[c] = (st_reg.srv[c] == SRV_BOOT);
			stored_busy[c] = (st_reg.srv[c] == SRV_STORED);
		end
		if (reg_rd) begin
			rhit = hds_map(reg_addr);
			st_next.rdata = rhit[5] ? st_reg.regs[rhit[4:0]] : 16'h0000;
			if (reg_addr == HDS_A_SRV_CTL) begin
				st_next.rdata[HDS_BOOT_TRIG_LSB +: 2] = boot_busy;
				st_next.rdata[HDS_STORED_TRIG_LSB +: 2] = stored_busy;
			end
			if (reg_addr == HDS_A_SEQ_GO) begin
				st_next.rdata[HDS_SEQ_GO_BIT] = (st_reg.seq != SEQ_IDLE);
			end
			if (reg_addr == HDS_A_SRV_STAT) begin
				st_next.rdata = 16'h0000;
				st_next.rdata[HDS_BOOT_DONE_LSB +: 2] = st_reg.boot_done;
				st_next.rdata[HDS_STORED_DONE_LSB +: 2] = st_reg.stored_done;
				st_next.rdata[HDS_ANY_DONE_LSB +: 2] = st_reg.boot_done
					| st_reg.stored_done;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata = st_reg.rdata;
	assign pump_on = st_reg.pump_on;
	assign pump_clk = st_reg.pump_clk;
	assign pump_high_mode = st_reg.pump_high;
	assign left_phones_on = st_reg.regs[I_PWR1][HDS_LOUT_BIT];
	assign right_phones_on = st_reg.regs[I_PWR1][HDS_ROUT_BIT];
	assign phones_stage = st_reg.regs[I_HP_STAGE][7:0];
	assign servo_left_on = st_reg.regs[I_SRV_CTL][HDS_ENA_LSB];
	assign servo_right_on = st_reg.regs[I_SRV_CTL][HDS_ENA_LSB + 1];
	// correction held between operations, so the offset stays removed
	assign left_correction = st_reg.corr[0];
	assign right_correction = st_reg.corr[1];
	assign seq_busy = st_reg.busy;

endmodule

`default_nettype wire

// ===== testbench/hds_ctrl_properties.sv
// Purpose: port-level properties of hds_ctrl
// Assumes: one clock domain, nrst synchronous active low, PUMP_DIV left at 8
// Notes: servo enable follow check stops once the sequencer has run, it writes 54h too
`timescale 1ns/1ps
`default_nettype none
module hds_ctrl_properties
	import hds_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic pump_on,
	input wire logic pump_clk,
	input wire logic servo_left_on,
	input wire logic servo_right_on,
	input wire logic [HDS_VAL_W-1:0] left_correction,
	input wire logic [HDS_VAL_W-1:0] right_correction,
	input wire logic seq_busy
);
	// ----------------------------------------------------------------
	// shadow of bus-written values
	// ----------------------------------------------------------------
	localparam logic [7:0] WA [3] = '{HDS_A_SRV_CTL, HDS_A_SRV_VAL, HDS_A_SEQ_EN};
	logic [15:0] w_reg [3];
	logic [1:0] quiet_reg [3];
	logic seq_seen_reg;
	always_ff @(posedge clk) begin
		seq_seen_reg <= nrst && (seq_seen_reg || seq_busy);
		for (int k = 0; k < 3; k++) begin
			if (!nrst) begin
				w_reg[k] <= 16'h0000;
				quiet_reg[k] <= 2'h3;
			end else if (reg_wr && reg_addr == WA[k]) begin
				w_reg[k] <= reg_wdata;
				quiet_reg[k] <= 2'h0;
			end else if (quiet_reg[k] != 2'h3) begin
				quiet_reg[k] <= quiet_reg[k] + 2'h1;
			end
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_ctl;
		reg_wr && reg_addr == HDS_A_SRV_CTL;
	endsequence
	sequence s_store_left;
		s_ctl and (reg_wdata[2] && reg_wdata[0] && !reg_wdata[4]);
	endsequence
	sequence s_store_right;
		s_ctl and (reg_wdata[3] && reg_wdata[1] && !reg_wdata[5]);
	endsequence
	sequence s_launch;
		reg_wr && reg_addr == HDS_A_SEQ_GO && reg_wdata[8] && !seq_busy;
	endsequence
	a_pump_off: assert property (reg_wr && reg_addr == HDS_A_PUMP
		&& !reg_wdata[15] |-> ##2 !pump_on[*4])
		else $error("pump still on after enable cleared");
	a_pump_no_osc: assert property (reg_wr && reg_addr == HDS_A_PWR1
		&& !reg_wdata[3] |-> ##2 !pump_on[*4])
		else $error("pump on without oscillator");
	a_pump_clk_idle: assert property (!pump_on && !$past(pump_on) |-> !pump_clk)
		else $error("pump clock runs while pump off");
	a_pump_clk_rate: assert property (pump_on && $changed(pump_clk)
		|=> ($stable(pump_clk) || !pump_on)[*7])
		else $error("pump clock divide wrong");
	a_servo_enable: assert property (!seq_seen_reg && quiet_reg[0] == 2'h3
		|-> servo_left_on == w_reg[0][0] && servo_right_on == w_reg[0][1])
		else $error("servo enable mismatch");
	a_store_left: assert property (s_store_left
		|-> ##[1:2] left_correction == w_reg[1][7:0])
		else $error("left stored value not loaded");
	a_store_right: assert property (s_store_right
		|-> ##[1:2] right_correction == w_reg[1][15:8])
		else $error("right stored value not loaded");
	a_trig_disabled: assert property (s_ctl and (reg_wdata[3] && !reg_wdata[1])
		|=> $stable(right_correction)[*4])
		else $error("disabled channel corrected");
	a_launch_go: assert property (s_launch and w_reg[2][8] |=> ##[0:1] seq_busy)
		else $error("sequencer did not start");
	a_launch_refused: assert property (s_launch and !w_reg[2][8] |=> !seq_busy[*3])
		else $error("sequencer started while disabled");
endmodule
bind hds_ctrl hds_ctrl_properties i_hds_ctrl_properties (.clk, .nrst, .reg_wr, .reg_addr,
	.reg_wdata, .pump_on, .pump_clk, .servo_left_on, .servo_right_on, .left_correction,
	.right_correction, .seq_busy);
`default_nettype wire

// ===== testbench/hds_host.sv
// Purpose: host model driving the decoded register port and the sequencer program port
// Assumes: one strobe per access, signals change 1 ns after the rising edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module hds_host
	import hds_pkg::*;
(
	input wire logic clk,
	input wire logic [15:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic prog_wr,
	output logic [3:0] prog_idx,
	output logic [HDS_ENT_W-1:0] prog_entry
);
	initial begin
		{reg_wr, reg_rd, prog_wr, reg_addr, reg_wdata, prog_idx, prog_entry} = '0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clk);
		#1;
		{reg_wr, reg_rd} = 2'b00;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		acc(1'b0, a, 16'h0000);
		d = reg_rdata;
	endtask
	task automatic ent(input logic [3:0] i, input logic [7:0] a, input logic [3:0] w,
		input logic [3:0] s, input logic [7:0] d, input logic [3:0] dl, input logic l);
		@(posedge clk);
		#1;
		prog_idx = i;
		prog_entry = {l, dl, d, s, w, a};
		prog_wr = 1'b1;
		@(posedge clk);
		#1;
		prog_wr = 1'b0;
	endtask
	// recommended start-up programme, then the launch writes
	task automatic startup();
		ent(4'h0, HDS_A_PUMP, 4'h1, 4'hF, 8'h01, 4'h0, 1'b0);
		ent(4'h1, HDS_A_MIXEN, 4'h2, 4'h4, 8'h03, 4'h0, 1'b0);
		ent(4'h2, HDS_A_PATH_L, 4'h1, 4'h6, 8'h01, 4'h0, 1'b0);
		ent(4'h3, HDS_A_PATH_R, 4'h1, 4'h4, 8'h01, 4'h0, 1'b0);
		ent(4'h4, HDS_A_MUTE_L, 4'h1, 4'h8, 8'h00, 4'h0, 1'b0);
		ent(4'h5, HDS_A_MUTE_R, 4'h1, 4'h8, 8'h00, 4'h0, 1'b0);
		ent(4'h6, HDS_A_LGAIN, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0);
		ent(4'h7, HDS_A_RGAIN, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0);
		ent(4'h8, HDS_A_PWR1, 4'h2, 4'h8, 8'h03, 4'h0, 1'b0);
		// servo triggered with outputs still shorted and muted
		ent(4'h9, HDS_A_HP_STAGE, 4'h6, 4'h0, 8'h22, 4'h0, 1'b0);
		ent(4'hA, HDS_A_SRV_CTL, 4'h6, 4'h0, 8'h33, 4'h9, 1'b0);
		ent(4'hB, HDS_A_HP_STAGE, 4'h8, 4'h0, 8'hEE, 4'h0, 1'b1);
		wr(HDS_A_PWR1, 16'h000B);
		wr(HDS_A_PWR2, 16'h60C0);
		wr(HDS_A_IN1_LINE, 16'h0000);
		wr(HDS_A_FIRST_INPUT_A_VOL, 16'h0100);
		wr(HDS_A_FIRST_INPUT_B_VOL, 16'h0100);
		wr(HDS_A_SEQ_EN, 16'h0100);
		wr(HDS_A_SEQ_GO, 16'h0100);
	endtask
endmodule
`default_nettype wire

// ===== testbench/hds_ctrl_tb.sv
// Purpose: self-checking bench for hds_ctrl
// Assumes: shortened counts BOOT_CYC 640, STORED_CYC 50, SEQ_UNIT_CYC 2
// Notes: boot step direction is not fixed, so both the step-up result C5h and the saturated step-down result 80h are accepted
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module hds_ctrl_tb;
	import hds_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cmp_l = 1'b1;
	logic cmp_r = 1'b0;
	logic reg_wr, reg_rd, prog_wr;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [3:0] prog_idx;
	logic [HDS_ENT_W-1:0] prog_entry;
	logic pump_on, pump_clk, pump_high_mode, l_on, r_on, srv_l, srv_r, seq_busy;
	logic [7:0] stage, l_cor, r_cor;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	// {expected mode, address, data} for the gain threshold cases
	localparam logic [24:0] tg_tab [4] = '{{1'b1, HDS_A_LGAIN, 16'h0031},
		{1'b0, HDS_A_LGAIN, 16'h0030}, {1'b1, HDS_A_RGAIN, 16'h0031},
		{1'b0, HDS_A_RGAIN, 16'h0030}};
	always #5 clk = ~clk;
	hds_host i_hds_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .prog_wr(prog_wr), .prog_idx(prog_idx),
		.prog_entry(prog_entry));
	hds_ctrl #(.BOOT_CYC(640), .STORED_CYC(50), .SEQ_UNIT_CYC(2)) i_hds_ctrl (.clk(clk),
		.nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .prog_wr(prog_wr), .prog_idx(prog_idx),
		.prog_entry(prog_entry), .servo_cmp_left(cmp_l), .servo_cmp_right(cmp_r),
		.pump_on(pump_on), .pump_clk(pump_clk), .pump_high_mode(pump_high_mode),
		.left_phones_on(l_on), .right_phones_on(r_on), .phones_stage(stage),
		.servo_left_on(srv_l), .servo_right_on(srv_r), .left_correction(l_cor),
		.right_correction(r_cor), .seq_busy(seq_busy));
	task automatic give_verdict();
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// the whole run needs about 2200 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_hds_host.rd(a, d);
		`CHK($sformatf("reg %h", a), e, d)
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int tg;
		logic prev;
		tick(12);
		nrst = 1'b1;
		rchk(HDS_A_PUMP, 16'h0000);
		rchk(HDS_A_SRV_STAT, 16'h0000);
		rchk(8'h99, 16'h0000);
		i_hds_host.wr(HDS_A_SEQ_GO, 16'h0100);
		tick(3);
		`CHK("seq_busy", 1'b0, seq_busy)
		i_hds_host.wr(HDS_A_PUMP, 16'h8000);
		tick(3);
		`CHK("pump_on", 1'b0, pump_on)
		i_hds_host.wr(HDS_A_PWR1, 16'h0008);
		tick(3);
		`CHK("pump_on", 1'b1, pump_on)
		tg = 0;
		prev = pump_clk;
		repeat (64) begin
			tick(1);
			tg += (pump_clk !== prev);
			prev = pump_clk;
		end
		`CHK("pump_clk toggles", 8, tg)
		i_hds_host.wr(HDS_A_PWR1, 16'h0000);
		tick(3);
		`CHK("pump_on no osc", 1'b0, pump_on)
		i_hds_host.wr(HDS_A_PWR1, 16'h0008);
		tick(3);
		`CHK("pump_on osc back", 1'b1, pump_on)
		i_hds_host.wr(HDS_A_PUMP, 16'h0000);
		tick(3);
		`CHK("pump off", 2'b00, {pump_on, pump_clk})
		foreach (tg_tab[k]) begin
			i_hds_host.wr(tg_tab[k][23:16], tg_tab[k][15:0]);
			tick(3);
			`CHK("pump_high_mode", tg_tab[k][24], pump_high_mode)
		end
		i_hds_host.wr(HDS_A_SRV_VAL, 16'h857F);
		i_hds_host.wr(HDS_A_SRV_CTL, 16'h0007);
		rchk(HDS_A_SRV_CTL, 16'h0007);
		`CHK("left_correction", 8'h7F, l_cor)
		tick(55);
		rchk(HDS_A_SRV_STAT, 16'h0110);
		rchk(HDS_A_SRV_CTL, 16'h0003);
		i_hds_host.wr(HDS_A_SRV_CTL, 16'h0009);
		tick(3);
		`CHK("right_correction", 8'h00, r_cor)
		i_hds_host.wr(HDS_A_SRV_CTL, 16'h000A);
		tick(55);
		`CHK("right_correction", 8'h85, r_cor)
		rchk(HDS_A_SRV_STAT, 16'h0330);
		i_hds_host.wr(HDS_A_SRV_CTL, 16'h0022);
		rchk(HDS_A_SRV_CTL, 16'h0022);
		rchk(HDS_A_SRV_STAT, 16'h0110);
		tick(700);
		rchk(HDS_A_SRV_CTL, 16'h0002);
		rchk(HDS_A_SRV_STAT, 16'h0312);
		tick(100);
		`CHK("right boot", 1'b1, r_cor === 8'hC5 || r_cor === 8'h80)
		i_hds_host.startup();
		for (int i = 0; i < 300 && srv_l !== 1'b1; i++) tick(1);
		rchk(HDS_A_SRV_CTL, 16'h0033);
		for (int i = 0; i < 3000 && seq_busy !== 1'b0; i++) tick(1);
		tick(3);
		`CHK("outputs", 12'hFEE, {pump_on, l_on, r_on, srv_l, stage})
		`CHK("servo_right_on", 1'b1, srv_r)
		rchk(HDS_A_MIXEN, 16'h0030);
		rchk(HDS_A_PATH_L, 16'h0040);
		rchk(HDS_A_PATH_R, 16'h0010);
		rchk(HDS_A_RGAIN, 16'h0130);
		rchk(HDS_A_PWR1, 16'h030B);
		rchk(HDS_A_SRV_STAT, 16'h0303);
		rchk(HDS_A_SEQ_GO, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
